// File: brr_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "brr_defines.svh"
module brr_top (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [11:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [11:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              standalone_mode,
  input  wire logic              meas_done,
  input  wire brr_pkg::brr_word_t ratio_one_in,
  input  wire brr_pkg::brr_word_t ratio_two_in,
  input  wire brr_pkg::brr_word_t ratio_three_in,
  input  wire brr_pkg::brr_word_t ratio_four_in,
  input  wire brr_pkg::brr_word_t compensated_sum_in,
  input  wire brr_pkg::brr_word_t temperature_ratio_in,
  input  wire brr_pkg::brr_word_t first_gauge_time_in,
  input  wire brr_pkg::brr_word_t calibration_in,
  input  wire logic [5:0]        supply_voltage_in,
  input  wire logic [143:0]      aux_words_in,
  input  wire logic [4:0]        entry_cause_in,
  input  wire logic [5:0]        fault_flags_in,
  input  wire brr_pkg::brr_keys_t key_pin,
  output logic                   start_new_cycle,
  output logic                   start_tdc_cycle,
  output logic [7:0]             result_gain_multiplier
);
  import brr_pkg::*;

  brr_key_if kif ();

  brr_key_edge #(
    .KEYS (4)
  ) u_keys (
    .aclk    (aclk),
    .aresetn (aresetn),
    .key_pin (key_pin),
    .kif     (kif)
  );

  // result area storage, slot = index minus area base
  brr_word_t   area_reg [`BRR_AREA_WORDS];
  brr_word_t   area_next [`BRR_AREA_WORDS];
  logic [10:0] flags_reg, flags_next;
  logic [7:0]  gain_reg, gain_next;
  logic        new_reg, new_next;
  logic        tdc_reg, tdc_next;
  brr_word_t   status_word;

  // write channel state
  brr_wstate_t wst_reg, wst_next;
  logic        aw_have_reg, aw_have_next;
  logic        w_have_reg, w_have_next;
  logic [7:0]  waddr_reg, waddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0]  wstrb_reg, wstrb_next;
  logic [1:0]  bresp_reg, bresp_next;

  // read channel state
  logic        rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0]  rresp_reg, rresp_next;

  logic [7:0]  area_base;
  logic [7:0]  rd_idx;
  logic [7:0]  rd_off;
  logic        rd_in_area;
  logic        wr_in_area;
  logic        wr_fire;

  function automatic brr_word_t brr_scale(input brr_word_t raw, input logic [7:0] gain);
    logic signed [31:0] prod;
    prod = $signed(raw) * $signed({1'b0, gain});
    return brr_word_t'(prod[23:0]);
  endfunction : brr_scale

  // live status: key levels and edge flags track the keys, the rest is per measurement
  always_comb begin
    status_word = '0;
    status_word[`BRR_ST_KEY_LSB +: 4]   = kif.state;
    status_word[`BRR_ST_CAUSE_LSB +: 5] = flags_reg[10:6];
    status_word[`BRR_ST_LOWSUP]         = flags_reg[5];
    status_word[`BRR_ST_TDCERR]         = flags_reg[4];
    status_word[`BRR_ST_RSVD]           = 1'b0;
    status_word[`BRR_ST_CPERR]          = flags_reg[3];
    status_word[`BRR_ST_GPERR]          = flags_reg[2];
    status_word[`BRR_ST_TIMEOUT]        = flags_reg[1];
    status_word[`BRR_ST_EXTINT]         = flags_reg[0];
    status_word[`BRR_ST_RISE_LSB +: 4]  = kif.rise;
    status_word[`BRR_ST_FALL_LSB +: 4]  = kif.fall;
  end

  assign area_base = standalone_mode ? `BRR_IDX_SA_BASE : `BRR_IDX_FE_BASE;
  assign rd_idx    = s_axi_araddr[9:2];
  assign rd_off    = rd_idx - area_base;
  assign rd_in_area = (rd_idx >= area_base) && (rd_off < 8'(`BRR_AREA_WORDS));
  assign wr_in_area = (waddr_reg >= area_base) && ((waddr_reg - area_base) < 8'(`BRR_AREA_WORDS));
  assign wr_fire   = (wst_reg == BRR_W_HAVE);

  // measurement capture; bus writes never reach this storage
  always_comb begin
    for (int i = 0; i < `BRR_AREA_WORDS; i++) begin
      area_next[i] = area_reg[i];
    end
    flags_next = flags_reg;
    if (meas_done) begin
      // gain applied here so the host sees ppm times 100 times gain
      area_next[`BRR_SLOT_RATIO_ONE]      = brr_scale(ratio_one_in, gain_reg);
      area_next[`BRR_SLOT_RATIO_ONE + 1]  = brr_scale(ratio_two_in, gain_reg);
      area_next[`BRR_SLOT_RATIO_ONE + 2]  = brr_scale(ratio_three_in, gain_reg);
      area_next[`BRR_SLOT_RATIO_ONE + 3]  = brr_scale(ratio_four_in, gain_reg);
      area_next[`BRR_SLOT_SUM]    = brr_scale(compensated_sum_in, gain_reg);
      area_next[`BRR_SLOT_TEMP]   = temperature_ratio_in;
      area_next[`BRR_SLOT_RAW]    = first_gauge_time_in;
      area_next[`BRR_SLOT_CAL]    = calibration_in;
      area_next[`BRR_SLOT_SUPPLY] = {18'h00000, supply_voltage_in};
      for (int i = 0; i < 6; i++) begin
        area_next[`BRR_SLOT_AUX + i] = aux_words_in[i*24 +: 24];
      end
      flags_next = {entry_cause_in, fault_flags_in};
    end
  end

  // write path: address and data taken in either order, one write at a time
  always_comb begin
    wst_next     = wst_reg;
    aw_have_next = aw_have_reg;
    w_have_next  = w_have_reg;
    waddr_next   = waddr_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bresp_next   = bresp_reg;
    gain_next    = gain_reg;
    new_next     = 1'b0;
    tdc_next     = 1'b0;
    case (wst_reg)
      BRR_W_IDLE: begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_have_next = 1'b1;
          waddr_next   = s_axi_awaddr[9:2];
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_have_next = 1'b1;
          wdata_next  = s_axi_wdata;
          wstrb_next  = s_axi_wstrb;
        end
        if (aw_have_next && w_have_next) begin
          wst_next = BRR_W_HAVE;
        end
      end
      BRR_W_HAVE: begin
        bresp_next = `BRR_RESP_OKAY;
        if (waddr_reg == `BRR_IDX_GAIN) begin
          if (wstrb_reg[0]) begin
            gain_next = wdata_reg[7:0];
          end
        end else if (waddr_reg == `BRR_IDX_CMD) begin
          if (wstrb_reg[0] && wdata_reg[7:0] == `BRR_OP_NEW_CYCLE) begin
            new_next = 1'b1;
          end else if (wstrb_reg[0] && wdata_reg[7:0] == `BRR_OP_TDC_CYCLE) begin
            tdc_next = 1'b1;
          end
        end else begin
          // read-only area and holes both refuse the write
          bresp_next = `BRR_RESP_SLVERR;
        end
        aw_have_next = 1'b0;
        w_have_next  = 1'b0;
        wst_next     = BRR_W_RESP;
      end
      BRR_W_RESP: begin
        if (s_axi_bready) begin
          wst_next = BRR_W_IDLE;
        end
      end
      default: begin
        wst_next     = BRR_W_IDLE;
        aw_have_next = 1'b0;
        w_have_next  = 1'b0;
      end
    endcase
  end

  // read path; a read is pure, nothing is cleared by it
  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next  = `BRR_RESP_OKAY;
      if (rd_in_area && rd_off[3:0] == `BRR_SLOT_STATUS) begin
        rdata_next = {8'h00, status_word};
      end else if (rd_in_area) begin
        rdata_next = {8'h00, area_reg[rd_off[3:0]]};
      end else if (rd_idx == `BRR_IDX_GAIN) begin
        rdata_next = {24'h000000, gain_reg};
      end else if (rd_idx == `BRR_IDX_CMD) begin
        rdata_next = 32'h00000000;
      end else begin
        rdata_next = 32'h00000000;
        rresp_next = `BRR_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < `BRR_AREA_WORDS; i++) begin
        area_reg[i] <= '0;
      end
      flags_reg   <= '0;
      gain_reg    <= `BRR_GAIN_RST;
      new_reg     <= 1'b0;
      tdc_reg     <= 1'b0;
      wst_reg     <= BRR_W_IDLE;
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      waddr_reg   <= '0;
      wdata_reg   <= '0;
      wstrb_reg   <= '0;
      bresp_reg   <= `BRR_RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= '0;
      rresp_reg   <= `BRR_RESP_OKAY;
    end else begin
      for (int i = 0; i < `BRR_AREA_WORDS; i++) begin
        area_reg[i] <= area_next[i];
      end
      flags_reg   <= flags_next;
      gain_reg    <= gain_next;
      new_reg     <= new_next;
      tdc_reg     <= tdc_next;
      wst_reg     <= wst_next;
      aw_have_reg <= aw_have_next;
      w_have_reg  <= w_have_next;
      waddr_reg   <= waddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  // edge flags are dropped when a fresh cycle is requested
  assign kif.clear = new_reg;

  assign s_axi_awready = (wst_reg == BRR_W_IDLE) && !aw_have_reg;
  assign s_axi_wready  = (wst_reg == BRR_W_IDLE) && !w_have_reg;
  assign s_axi_bvalid  = (wst_reg == BRR_W_RESP);
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign start_new_cycle = new_reg;
  assign start_tdc_cycle = tdc_reg;
  assign result_gain_multiplier = gain_reg;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  new_cycle_cmd_a: assert property (wr_fire && waddr_reg == `BRR_IDX_CMD && wstrb_reg[0]
      && wdata_reg[7:0] == 8'hCC |=> start_new_cycle && !start_tdc_cycle)
    else $error("0xCC did not start a new cycle");
  tdc_cycle_cmd_a: assert property (wr_fire && waddr_reg == `BRR_IDX_CMD && wstrb_reg[0]
      && wdata_reg[7:0] == 8'hCE |=> start_tdc_cycle ##1 !start_tdc_cycle)
    else $error("0xCE did not give one converter start");
  area_ro_a: assert property (wr_fire && wr_in_area |=> s_axi_bvalid
      && s_axi_bresp == 2'h2)
    else $error("write to result area not refused");
  area_stable_a: assert property (!meas_done |=> area_reg[0] == $past(area_reg[0]))
    else $error("result word changed without a measurement");
  ratio_gain_a: assert property (meas_done |=> area_reg[0]
      == brr_word_t'($past(ratio_one_in) * $past(gain_reg)))
    else $error("first bridge word not gain scaled");
  supply_cap_a: assert property (meas_done |=> area_reg[9][23:6] == 18'h00000
      && area_reg[9][5:0] == $past(supply_voltage_in))
    else $error("supply code misplaced");
  temp_cap_a: assert property (meas_done |=> area_reg[5] == $past(temperature_ratio_in))
    else $error("temperature word not captured");
  cal_raw_a: assert property (meas_done |=> area_reg[8] == $past(calibration_in)
      && area_reg[7] == $past(first_gauge_time_in))
    else $error("calibration or raw time not captured");
  status_read_a: assert property (s_axi_arvalid && s_axi_arready && rd_in_area
      && rd_off == 8'h06 |=> s_axi_rdata[23:20] == $past(kif.state)
      && s_axi_rdata[7:4] == $past(kif.rise) && s_axi_rdata[12] == 1'b0)
    else $error("status word read wrong");
  flags_cap_a: assert property (meas_done |=> flags_reg
      == $past({entry_cause_in, fault_flags_in}))
    else $error("entry cause or fault flags not captured");
  base_sel_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[9:2] == 8'hF0
      && !standalone_mode |=> s_axi_rresp == 2'h2)
    else $error("stand-alone area answered in front-end operation");
  resp_bound_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");

  read_area_c: cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == 2'h0);
  new_cycle_c: cover property (start_new_cycle);
  tdc_cycle_c: cover property (start_tdc_cycle);
  sa_read_c:   cover property (standalone_mode && s_axi_arvalid && s_axi_arready && rd_in_area);
endmodule : brr_top
`default_nettype wire

// File: brr_defines.svh
`ifndef BRR_DEFINES_SVH
`define BRR_DEFINES_SVH
// word indices; byte address is four times the index
`define BRR_IDX_GAIN          8'h01
`define BRR_IDX_CMD           8'h02
`define BRR_IDX_FE_BASE       8'h10
`define BRR_IDX_SA_BASE       8'hF0
`define BRR_AREA_WORDS        16
// slots inside the result area
`define BRR_SLOT_RATIO_ONE    4'h0
`define BRR_SLOT_SUM          4'h4
`define BRR_SLOT_TEMP         4'h5
`define BRR_SLOT_STATUS       4'h6
`define BRR_SLOT_RAW          4'h7
`define BRR_SLOT_CAL          4'h8
`define BRR_SLOT_SUPPLY       4'h9
`define BRR_SLOT_AUX          4'hA
// status word fields
`define BRR_ST_KEY_LSB        20
`define BRR_ST_CAUSE_LSB      15
`define BRR_ST_LOWSUP         14
`define BRR_ST_TDCERR         13
`define BRR_ST_RSVD           12
`define BRR_ST_CPERR          11
`define BRR_ST_GPERR          10
`define BRR_ST_TIMEOUT        9
`define BRR_ST_EXTINT         8
`define BRR_ST_RISE_LSB       4
`define BRR_ST_FALL_LSB       0
// reset values and opcodes
`define BRR_GAIN_RST          8'h01
`define BRR_OP_NEW_CYCLE      8'hCC
`define BRR_OP_TDC_CYCLE      8'hCE
`define BRR_RESP_OKAY         2'h0
`define BRR_RESP_SLVERR       2'h2
`endif

// File: brr_pkg.sv
package brr_pkg;
  typedef logic [23:0] brr_word_t;
  typedef logic [3:0]  brr_keys_t;
  typedef enum logic [2:0] {
    BRR_W_IDLE = 3'h1,
    BRR_W_HAVE = 3'h2,
    BRR_W_RESP = 3'h4
  } brr_wstate_t;
endpackage : brr_pkg

// File: brr_key_if.sv
`timescale 1ns/100ps
`default_nettype none
interface brr_key_if;
  logic [3:0] state;
  logic [3:0] rise;
  logic [3:0] fall;
  logic       clear;
  modport edge_side (output state, output rise, output fall, input clear);
  modport reg_side  (input state, input rise, input fall, output clear);
endinterface : brr_key_if
`default_nettype wire

// File: brr_key_edge.sv
`timescale 1ns/100ps
`default_nettype none
module brr_key_edge #(
  parameter int KEYS = 4
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [KEYS-1:0] key_pin,
  brr_key_if.edge_side       kif
);
  import brr_pkg::*;
  logic [KEYS-1:0] meta_reg, meta_next;
  logic [KEYS-1:0] sync_reg, sync_next;
  logic [KEYS-1:0] last_reg, last_next;
  logic [KEYS-1:0] rise_reg, rise_next;
  logic [KEYS-1:0] fall_reg, fall_next;

  always_comb begin
    meta_next = key_pin;
    sync_next = meta_reg;
    last_next = sync_reg;
    // a new edge outranks a clear in the same cycle
    rise_next = (kif.clear ? '0 : rise_reg) | (sync_reg & ~last_reg);
    fall_next = (kif.clear ? '0 : fall_reg) | (~sync_reg & last_reg);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= '0;
      sync_reg <= '0;
      last_reg <= '0;
      rise_reg <= '0;
      fall_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      last_reg <= last_next;
      rise_reg <= rise_next;
      fall_reg <= fall_next;
    end
  end

  assign kif.state = sync_reg;
  assign kif.rise  = rise_reg;
  assign kif.fall  = fall_reg;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  rise_sets_a: assert property (sync_reg[0] && !last_reg[0] |=> rise_reg[0])
    else $error("rising key edge not recorded");
  fall_sets_a: assert property (!sync_reg[0] && last_reg[0] |=> fall_reg[0])
    else $error("falling key edge not recorded");
endmodule : brr_key_edge
`default_nettype wire

// File: brr_front_model.sv
`timescale 1ns/100ps
`default_nettype none
module brr_front_model #(
  parameter int         DLY   = 5,
  parameter logic [4:0] CAUSE = 5'h13,
  parameter logic [5:0] FLT   = 6'h25
) (
  input  wire logic     aclk,
  input  wire logic     aresetn,
  input  wire logic     start_new_cycle,
  input  wire logic     start_tdc_cycle,
  output logic          meas_done,
  output logic [383:0]  words,
  output logic [4:0]    entry_cause,
  output logic [5:0]    fault_flags
);
  int           cnt_reg;
  int           cnt_next;
  logic [383:0] good;
  always_comb begin
    cnt_next = (cnt_reg != 0) ? cnt_reg - 1 : 0;
    // one result per start, never free running
    if (start_new_cycle || start_tdc_cycle) begin
      cnt_next = DLY;
    end
    for (int k = 0; k < 16; k++) begin
      good[k*24+:24] = (k == 1) ? 24'hFFFFFF : {8'(k), 16'h86A0};
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) cnt_reg <= 0;
    else cnt_reg <= cnt_next;
  end
  // values valid only in the done cycle, inverted otherwise so a late capture shows
  assign meas_done   = (cnt_reg == 1);
  assign words       = meas_done ? good : ~good;
  assign entry_cause = meas_done ? CAUSE : ~CAUSE;
  assign fault_flags = meas_done ? FLT : ~FLT;
endmodule : brr_front_model
`default_nettype wire

// File: tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "brr_defines.svh"
module tb;
  import brr_pkg::*;
  localparam logic [4:0] CAUSE = 5'h13;
  localparam logic [5:0] FLT   = 6'h25;
  logic         aclk, aresetn, standalone, meas_done, start_new, start_tdc;
  logic [11:0]  awaddr, araddr;
  logic [31:0]  wdata, rdata, d;
  logic [3:0]   wstrb, strb;
  logic [1:0]   bresp, rresp, r;
  logic         awvalid, awready, wvalid, wready, bvalid, bready;
  logic         arvalid, arready, rvalid, rready;
  brr_keys_t    key_pin;
  logic [7:0]   gain;
  logic [383:0] words;
  logic [4:0]   cause;
  logic [5:0]   fault;
  int           err_total, samples_checked, cyc, n_new, n_tdc;

  brr_top i_brr_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .standalone_mode(standalone), .meas_done(meas_done),
    .ratio_one_in(words[0+:24]), .ratio_two_in(words[24+:24]),
    .ratio_three_in(words[48+:24]), .ratio_four_in(words[72+:24]),
    .compensated_sum_in(words[96+:24]), .temperature_ratio_in(words[120+:24]),
    .first_gauge_time_in(words[168+:24]), .calibration_in(words[192+:24]),
    .supply_voltage_in(words[216+:6]), .aux_words_in(words[240+:144]),
    .entry_cause_in(cause), .fault_flags_in(fault), .key_pin(key_pin),
    .start_new_cycle(start_new), .start_tdc_cycle(start_tdc),
    .result_gain_multiplier(gain));
  brr_front_model #(.DLY(5), .CAUSE(CAUSE), .FLT(FLT)) i_brr_front_model (
    .aclk(aclk), .aresetn(aresetn), .start_new_cycle(start_new),
    .start_tdc_cycle(start_tdc), .meas_done(meas_done), .words(words),
    .entry_cause(cause), .fault_flags(fault));

  always #2 aclk = ~aclk;
  // pulses are counted mid-cycle, away from the edge that launches them
  always @(negedge aclk) begin
    n_new += int'(start_new);
    n_tdc += int'(start_tdc);
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      $display("mismatch timeout expected 0 seen 1");
      summarize();
    end
  end

  function automatic logic [23:0] wv(input int k);
    return (k == 1) ? 24'hFFFFFF : {8'(k), 16'h86A0};
  endfunction : wv
  function automatic logic [31:0] ex(input int s, input logic [7:0] g);
    logic [23:0] w;
    w = wv(s);
    if (s <= 4) w = 24'(w * g);
    if (s == 9) w = {18'h0, w[5:0]};
    return {8'h00, w};
  endfunction : ex
  function automatic logic [31:0] st(input logic [3:0] k, input logic [3:0] ri,
                                     input logic [3:0] fa);
    return {8'h00, k, CAUSE, FLT[5:4], 1'b0, FLT[3:0], ri, fa};
  endfunction : st

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic axw(input logic [11:0] a, input logic [31:0] dv, output logic [1:0] rs);
    logic ta, tw, tk;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= dv;
    wstrb   <= strb;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    tk = 1'b0;
    while (!tk) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tk = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [11:0] a, output logic [31:0] dv, output logic [1:0] rs);
    logic ta, tk;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    tk = 1'b0;
    while (!tk) begin
      @(negedge aclk);
      ta = arvalid && arready;
      tk = rvalid;
      dv = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask : axr

  task automatic t_reset;
    axr(12'h004, d, r);
    chk("gain_reset", d, 32'h1);
    chk("gain_out_reset", {24'h0, gain}, 32'h1);
    axr(12'h040, d, r);
    chk("result_reset", d, 32'h0);
  endtask : t_reset
  task automatic t_cmd;
    logic [7:0] op [3] = '{8'hCC, 8'hCE, 8'h55};
    int nn, nt;
    axw(12'h004, 32'h4, r);
    chk("gain_wr_resp", {30'h0, r}, {30'h0, `BRR_RESP_OKAY});
    chk("gain_out", {24'h0, gain}, 32'h4);
    for (int i = 0; i < 3; i++) begin
      nn = n_new;
      nt = n_tdc;
      axw(12'h008, {24'h0, op[i]}, r);
      @(posedge aclk);
      chk("cmd_resp", {30'h0, r}, {30'h0, `BRR_RESP_OKAY});
      chk("new_pulses", 32'(n_new - nn), 32'(i == 0));
      chk("tdc_pulses", 32'(n_tdc - nt), 32'(i == 1));
    end
    axr(12'h008, d, r);
    chk("cmd_read", d, 32'h0);
    repeat (10) @(posedge aclk);
  endtask : t_cmd
  task automatic t_results;
    for (int s = 0; s < 16; s++) begin
      if (s != 6) begin
        axr(12'(32'h40 + s * 4), d, r);
        chk("result", d, ex(s, 8'h04));
        chk("result_resp", {30'h0, r}, {30'h0, `BRR_RESP_OKAY});
      end
    end
  endtask : t_results
  task automatic t_status;
    @(posedge aclk);
    key_pin <= 4'h5;
    repeat (6) @(posedge aclk);
    axr(12'h058, d, r);
    chk("status_rise", d, st(4'h5, 4'h5, 4'h0));
    key_pin <= 4'h1;
    repeat (6) @(posedge aclk);
    axr(12'h058, d, r);
    chk("status_fall", d, st(4'h1, 4'h5, 4'h4));
    axw(12'h008, 32'hCC, r);
    repeat (12) @(posedge aclk);
    axr(12'h058, d, r);
    chk("status_clear", d, st(4'h1, 4'h0, 4'h0));
    // key one released so its falling edge is seen too
    key_pin <= 4'h0;
    repeat (6) @(posedge aclk);
    axr(12'h058, d, r);
    chk("status_fall_one", d, st(4'h0, 4'h0, 4'h1));
  endtask : t_status
  task automatic t_access;
    // writes into the result area must bounce and leave the words alone
    axw(12'h040, 32'h00ABCDEF, r);
    chk("area_wr_resp", {30'h0, r}, {30'h0, `BRR_RESP_SLVERR});
    axw(12'h058, 32'h0, r);
    chk("status_wr_resp", {30'h0, r}, {30'h0, `BRR_RESP_SLVERR});
    repeat (2) begin
      axr(12'h040, d, r);
      chk("area_after_wr", d, ex(0, 8'h04));
    end
    axr(12'h100, d, r);
    chk("hole_resp", {30'h0, r}, {30'h0, `BRR_RESP_SLVERR});
    chk("hole_data", d, 32'h0);
    // lane zero off: the gain must keep its value
    strb = 4'hE;
    axw(12'h004, 32'h9, r);
    strb = 4'hF;
    axr(12'h004, d, r);
    chk("gain_rd", d, 32'h4);
  endtask : t_access
  task automatic t_standalone;
    axr(12'h3C0, d, r);
    chk("fe_sa_resp", {30'h0, r}, {30'h0, `BRR_RESP_SLVERR});
    @(posedge aclk);
    standalone <= 1'b1;
    axr(12'h3C0, d, r);
    chk("sa_ratio", d, ex(0, 8'h04));
    axr(12'h3E4, d, r);
    chk("sa_supply", d, ex(9, 8'h04));
    axr(12'h040, d, r);
    chk("sa_fe_resp", {30'h0, r}, {30'h0, `BRR_RESP_SLVERR});
    standalone <= 1'b0;
  endtask : t_standalone

  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awaddr, araddr, wdata, wstrb, key_pin} = '0;
    strb = 4'hF;
    {awvalid, wvalid, bready, arvalid, rready, standalone} = '0;
    {err_total, samples_checked, cyc, n_new, n_tdc} = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_cmd();
    t_results();
    t_status();
    t_access();
    t_standalone();
    summarize();
  end
endmodule : tb
`default_nettype wire
